// ==== src/gdm_pkg.sv ====
// constants and types for the gate drive monitor configuration bank
// Functional notes
// - the low-current select register at 17h resets to zero and holds one bit per bridge, bit 7 for bridge 1 down to bit 0 for bridge 8.
// - a clear low-current bit maps a bridge's source and sink codes to the standard table, a set bit to the low-current table.
// - each 4-bit current code picks one of sixteen currents, code 1111b giving 62 mA standard or 2.3 mA low-current.
// - the monitor register at 18h resets to zero and bits 7-6 set the gate fault mode: latched, cycle by cycle, warning, disabled.
// - gate fault local shutdown bit 5 clear shuts all drivers on a gate fault, set shuts only the faulting bridge.
// - bit 4 picks the gate comparator threshold, 1.4 V when clear and 1 V when set.
// - handshake disable bit 3 removes the gate-voltage dead-time handshake.
// - bits 2-1 set the overcurrent mode: latched, cycle by cycle, warning, disabled.
// - overcurrent local shutdown bit 0 clear shuts all drivers on an overcurrent, set shuts only the affected bridge.
// - the blanking register at 19h resets to 12h, bits 7-6 read zero, bits 5-3 serve bridges 1-2 and bits 2-0 bridges 3-4.
// - each 3-bit blanking code selects 2, 4, 8, 12, 16, 24, 32 or 96 us of drive and overcurrent blanking.
package gdm_pkg;
  localparam int         NUM_HB          = 8;
  localparam logic [7:0] ADDR_LOW_CUR    = 8'h17;
  localparam logic [7:0] ADDR_MON_CFG    = 8'h18;
  localparam logic [7:0] ADDR_BLANK_LO   = 8'h19;
  localparam logic [7:0] RST_LOW_CUR     = 8'h00;
  localparam logic [7:0] RST_MON_CFG     = 8'h00;
  localparam logic [7:0] RST_BLANK_LO    = 8'h12;
  localparam logic [7:0] BLANK_WR_MASK   = 8'h3F;
  localparam int         POS_GATE_MODE   = 6;
  localparam int         POS_GATE_LOCAL  = 5;
  localparam int         POS_THRESH      = 4;
  localparam int         POS_HS_DIS      = 3;
  localparam int         POS_OC_MODE     = 1;
  localparam int         POS_OC_LOCAL    = 0;
  localparam int         POS_BLANK_HB12  = 3;
  localparam int         POS_BLANK_HB34  = 0;
  localparam int         CLK_MHZ         = 40;
  // blanking windows in microseconds, indexed by code
  localparam int         BLANK_US [8]    = '{2, 4, 8, 12, 16, 24, 32, 96};
  // current tables in microamps, indexed by code
  localparam int         STD_UA [16]     = '{500, 1000, 2000, 3000, 4000, 5000, 6000, 7000,
                                             8000, 12000, 16000, 20000, 24000, 31000, 48000,
                                             62000};
  localparam int         LOW_UA [16]     = '{50, 110, 170, 230, 290, 350, 410, 600,
                                             725, 850, 1000, 1200, 1400, 1600, 1800, 2300};
  localparam int         THRESH_HI_MV    = 1400;
  localparam int         THRESH_LO_MV    = 1000;

  typedef enum logic [1:0] {
    MODE_LATCHED = 2'b00,
    MODE_CYCLE   = 2'b01,
    MODE_WARN    = 2'b10,
    MODE_OFF     = 2'b11
  } mon_mode_t;
endpackage : gdm_pkg

// ==== src/gdm_blank_timer.sv ====
// per-bridge drive and blanking window timer
`timescale 1ns/100ps
`default_nettype none
module gdm_blank_timer (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic [2:0] code,
  output logic            active
);
  import gdm_pkg::*;

  typedef struct packed {
    logic [11:0] cnt;
  } tmr_t;

  tmr_t st_q, st_d;
  logic [11:0] load_val;

  always_comb begin
    load_val = 12'(BLANK_US[code] * CLK_MHZ);
    st_d     = st_q;
    if (start) begin
      st_d.cnt = load_val;
    end else if (st_q.cnt != 12'h000) begin
      st_d.cnt = st_q.cnt - 12'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign active = (st_q.cnt != 12'h000);

  // load at the start edge, then 80 counts down to zero: active for 80 sampled edges
  a_blank_len: assert property (@(posedge clk) disable iff (!reset_n)
    start && code == 3'b000 |=> active [*8] ##73 !active)
    else $error("blanking window not 2 us");
endmodule : gdm_blank_timer
`default_nettype wire

// ==== src/gate_drive_monitor_config.sv ====
// register bank and monitor response logic of the gate driver
`timescale 1ns/100ps
`default_nettype none
module gate_drive_monitor_config (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_valid,
  input  wire logic [7:0]        hb_switch,
  input  wire logic [7:0]        gate_fault_raw,
  input  wire logic [7:0]        oc_fault_raw,
  input  wire logic              fault_clear,
  output logic      [7:0]        low_current_sel,
  output logic      [7:0]        driver_enable,
  output logic      [7:0]        blanking_active,
  output logic      [7:0]        gate_warning,
  output logic      [7:0]        oc_warning,
  output logic                   gate_threshold_select,
  output logic                   handshake_disable,
  output logic [gdm_pkg::NUM_HB-1:0][15:0] peak_current_ua
);
  import gdm_pkg::*;

  // peak_current_ua for the code 1111b on both source and sink, per bridge
  typedef struct packed {
    logic [7:0] low_cur;
    logic [7:0] mon_cfg;
    logic [7:0] blank;
    logic [7:0] rdata;
    logic       valid;
    logic [7:0] latched_off;
    logic [7:0] gate_s1;
    logic [7:0] gate_s2;
    logic [7:0] oc_s1;
    logic [7:0] oc_s2;
    logic [7:0] sw_s1;
    logic [7:0] sw_s2;
    logic [7:0] sw_prev;
  } state_t;

  state_t st_q, st_d;
  mon_mode_t   gate_mode, oc_mode;
  logic [7:0]  gate_hit, oc_hit, gate_trip, oc_trip, shut_now, edge_hb;
  logic [2:0]  hb_code [NUM_HB];
  logic [7:0]  read_val;
  logic        gate_local, oc_local;

  ////////////////////////////////////////////////////////////////////////////
  assign gate_mode  = mon_mode_t'(st_q.mon_cfg[POS_GATE_MODE +: 2]);
  assign oc_mode    = mon_mode_t'(st_q.mon_cfg[POS_OC_MODE +: 2]);
  assign gate_local = st_q.mon_cfg[POS_GATE_LOCAL];
  assign oc_local   = st_q.mon_cfg[POS_OC_LOCAL];
  assign edge_hb    = st_q.sw_s2 ^ st_q.sw_prev;

  // overcurrent is ignored while the bridge's blanking window is running
  assign gate_hit   = (gate_mode == MODE_OFF) ? 8'h00 : st_q.gate_s2;
  assign oc_hit     = (oc_mode == MODE_OFF) ? 8'h00 : (st_q.oc_s2 & ~blanking_active);

  assign gate_trip  = (gate_mode == MODE_WARN) ? 8'h00 : gate_hit;
  assign oc_trip    = (oc_mode == MODE_WARN) ? 8'h00 : oc_hit;
  assign gate_warning = gate_hit;
  assign oc_warning   = oc_hit;

  // shutdown spread: all bridges unless the local option is set
  always_comb begin
    shut_now = 8'h00;
    if (gate_trip != 8'h00) begin
      shut_now = shut_now | (gate_local ? gate_trip : 8'hFF);
    end
    if (oc_trip != 8'h00) begin
      shut_now = shut_now | (oc_local ? oc_trip : 8'hFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bridge n maps to register bit 8-n
  genvar g;
  generate
    for (g = 0; g < NUM_HB; g++) begin : g_hb
      assign low_current_sel[g] = st_q.low_cur[7-g];
      assign hb_code[g] = (g < 2) ? st_q.blank[POS_BLANK_HB12 +: 3]
                                  : st_q.blank[POS_BLANK_HB34 +: 3];
      // code 1111b current for the selected table
      assign peak_current_ua[g] = low_current_sel[g] ? 16'(LOW_UA[15])
                                                     : 16'(STD_UA[15]);
      // bridges 5-8 have their blanking elsewhere; only 1-4 time here
      if (g < 4) begin : g_tmr
        gdm_blank_timer gdm_blank_timer_inst (
          .clk     (clk),
          .reset_n (reset_n),
          .start   (edge_hb[g]),
          .code    (hb_code[g]),
          .active  (blanking_active[g])
        );
      end else begin : g_none
        assign blanking_active[g] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (reg_addr)
      ADDR_LOW_CUR:  read_val = st_q.low_cur;
      ADDR_MON_CFG:  read_val = st_q.mon_cfg;
      ADDR_BLANK_LO: read_val = st_q.blank & BLANK_WR_MASK;
      default:       read_val = 8'h00;
    endcase
  end

  always_comb begin
    st_d         = st_q;
    st_d.gate_s1 = gate_fault_raw;
    st_d.gate_s2 = st_q.gate_s1;
    st_d.oc_s1   = oc_fault_raw;
    st_d.oc_s2   = st_q.oc_s1;
    st_d.sw_s1   = hb_switch;
    st_d.sw_s2   = st_q.sw_s1;
    st_d.sw_prev = st_q.sw_s2;
    st_d.valid   = reg_rd;
    if (reg_rd) begin
      st_d.rdata = read_val;
    end
    if (reg_wr) begin
      case (reg_addr)
        ADDR_LOW_CUR:  st_d.low_cur = reg_wdata;
        ADDR_MON_CFG:  st_d.mon_cfg = reg_wdata;
        ADDR_BLANK_LO: st_d.blank   = reg_wdata & BLANK_WR_MASK;
        default:       st_d.low_cur = st_q.low_cur;
      endcase
    end
    // latched faults hold until cleared; a new trip wins over the clear
    if (fault_clear) begin
      st_d.latched_off = 8'h00;
    end
    if (gate_mode == MODE_LATCHED) begin
      st_d.latched_off = st_d.latched_off | (gate_local ? gate_trip
                         : {8{gate_trip != 8'h00}});
    end
    if (oc_mode == MODE_LATCHED) begin
      st_d.latched_off = st_d.latched_off | (oc_local ? oc_trip
                         : {8{oc_trip != 8'h00}});
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q         <= '0;
      st_q.low_cur <= RST_LOW_CUR;
      st_q.mon_cfg <= RST_MON_CFG;
      st_q.blank   <= RST_BLANK_LO;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle-by-cycle faults only gate the driver while present
  assign driver_enable         = ~(shut_now | st_q.latched_off);
  assign gate_threshold_select = st_q.mon_cfg[POS_THRESH];
  assign handshake_disable     = st_q.mon_cfg[POS_HS_DIS];
  assign reg_rdata             = st_q.rdata;
  assign reg_valid             = st_q.valid;

  a_blank_rsvd: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == ADDR_BLANK_LO |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved blanking bits not zero");
  a_lowcur_map: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_LOW_CUR |=> low_current_sel[0] == $past(reg_wdata[7]))
    else $error("bridge 1 low-current bit not bit 7");
  a_table_sel: assert property (@(posedge clk) disable iff (!reset_n)
    peak_current_ua[2] == (low_current_sel[2] ? 16'd2300 : 16'd62000))
    else $error("bridge 3 current table wrong");
  a_gate_global: assert property (@(posedge clk) disable iff (!reset_n)
    gate_mode == MODE_CYCLE && !gate_local && st_q.gate_s2 != 8'h00
    |-> driver_enable == 8'h00)
    else $error("gate fault did not stop all drivers");
  a_oc_local: assert property (@(posedge clk) disable iff (!reset_n)
    oc_mode == MODE_CYCLE && oc_local && gate_trip == 8'h00
    && st_q.latched_off == 8'h00 && oc_hit != 8'h00 |-> driver_enable == ~oc_hit)
    else $error("overcurrent local shutdown wrong");
  a_oc_off: assert property (@(posedge clk) disable iff (!reset_n)
    oc_mode == MODE_OFF |-> oc_warning == 8'h00)
    else $error("disabled overcurrent still reports");
  a_thresh_bit: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_MON_CFG |=> gate_threshold_select == $past(reg_wdata[4])
    && handshake_disable == $past(reg_wdata[3]))
    else $error("threshold or handshake bit wrong");
  a_gate_latch: assert property (@(posedge clk) disable iff (!reset_n)
    gate_mode == MODE_LATCHED && !gate_local && gate_trip != 8'h00 && !fault_clear
    |=> driver_enable == 8'h00 [*2])
    else $error("latched gate fault not held");
  a_gate_local: assert property (@(posedge clk) disable iff (!reset_n)
    gate_mode == MODE_CYCLE && gate_local && oc_trip == 8'h00
    && st_q.latched_off == 8'h00 && gate_hit != 8'h00 |-> driver_enable == ~gate_hit)
    else $error("gate local shutdown wrong");
  a_oc_global: assert property (@(posedge clk) disable iff (!reset_n)
    oc_mode == MODE_CYCLE && !oc_local && oc_hit != 8'h00 |-> driver_enable == 8'h00)
    else $error("overcurrent did not stop all drivers");
  a_gate_off: assert property (@(posedge clk) disable iff (!reset_n)
    gate_mode == MODE_OFF && oc_trip == 8'h00 && st_q.latched_off == 8'h00
    |-> gate_warning == 8'h00 && driver_enable == 8'hFF)
    else $error("disabled gate monitor still acts");
  a_gate_warn_only: assert property (@(posedge clk) disable iff (!reset_n)
    gate_mode == MODE_WARN && oc_trip == 8'h00 && st_q.latched_off == 8'h00
    |-> gate_warning == st_q.gate_s2 && driver_enable == 8'hFF)
    else $error("gate warning mode shut a driver");
  a_oc_warn_only: assert property (@(posedge clk) disable iff (!reset_n)
    oc_mode == MODE_WARN && gate_trip == 8'h00 && st_q.latched_off == 8'h00
    |-> driver_enable == 8'hFF)
    else $error("overcurrent warning mode shut a driver");
  a_mon_write: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_MON_CFG |=> st_q.mon_cfg == $past(reg_wdata))
    else $error("monitor register write lost");
  a_blank_write: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == ADDR_BLANK_LO |=> st_q.blank[7:6] == 2'b00
    && st_q.blank[5:0] == $past(reg_wdata[5:0]))
    else $error("blanking register write wrong");
endmodule : gate_drive_monitor_config
`default_nettype wire

// ==== dv/gate_circuit_model.sv ====
// behavioural model of the external half-bridge gate circuits
`timescale 1ns/100ps
`default_nettype none
module gate_circuit_model (
  input  wire logic       clk,
  input  wire logic [7:0] switch_cmd,
  input  wire logic [7:0] gate_short,
  input  wire logic [7:0] drain_short,
  output logic      [7:0] hb_switch,
  output logic      [7:0] gate_fault_raw,
  output logic      [7:0] oc_fault_raw
);
  // levels move on the falling edge, clear of the sampling edge
  always_ff @(negedge clk) begin
    hb_switch      <= switch_cmd;
    gate_fault_raw <= gate_short;
    oc_fault_raw   <= drain_short;
  end
endmodule : gate_circuit_model
`default_nettype wire

// ==== dv/gate_drive_monitor_config_tb.sv ====
// self-checking testbench of the gate drive monitor configuration bank
`timescale 1ns/100ps
`default_nettype none
module gate_drive_monitor_config_tb;
  import gdm_pkg::*;
  logic       clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, fault_clear = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, switch_cmd = 0;
  logic [7:0] gate_short = 0, drain_short = 0;
  logic [7:0] reg_rdata, hb_switch, gate_fault_raw, oc_fault_raw, low_current_sel;
  logic [7:0] driver_enable, blanking_active, gate_warning, oc_warning;
  logic       reg_valid, gate_threshold_select, handshake_disable;
  logic [NUM_HB-1:0][15:0] peak_current_ua;
  int         fail_count = 0, tests_run = 0;

  gate_drive_monitor_config gate_drive_monitor_config_inst (
    .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_valid(reg_valid), .hb_switch(hb_switch), .gate_fault_raw(gate_fault_raw),
    .oc_fault_raw(oc_fault_raw), .fault_clear(fault_clear),
    .low_current_sel(low_current_sel), .driver_enable(driver_enable),
    .blanking_active(blanking_active), .gate_warning(gate_warning),
    .oc_warning(oc_warning), .gate_threshold_select(gate_threshold_select),
    .handshake_disable(handshake_disable), .peak_current_ua(peak_current_ua));
  gate_circuit_model gate_circuit_model_inst (
    .clk(clk), .switch_cmd(switch_cmd), .gate_short(gate_short),
    .drain_short(drain_short), .hb_switch(hb_switch),
    .gate_fault_raw(gate_fault_raw), .oc_fault_raw(oc_fault_raw));

  initial begin
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check8
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check16
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(negedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(negedge clk);
    reg_rd <= 1'b0;
    check8({7'h00, reg_valid}, 8'h01, "read valid");
    check8(reg_rdata, e, "read data");
  endtask : rd
  // one fault on bridge 3 (gate) or bridge 6 (drain), no blanking there
  task automatic fault_case(input logic gate, input logic [1:0] m, input logic l);
    logic [7:0] hit, en;
    hit = gate ? 8'h04 : 8'h20;
    en = (m < 2'b10) ? (l ? ~hit : 8'h00) : 8'hFF;
    wr(8'h18, gate ? {m, l, 5'h00} : {5'h00, m, l});
    if (gate) begin
      gate_short <= hit;
    end else begin
      drain_short <= hit;
    end
    cycles(5);
    check8(driver_enable, en, "shutdown");
    check8(gate ? gate_warning : oc_warning, (m != 2'b11) ? hit : 8'h00, "warn");
    gate_short  <= 8'h00;
    drain_short <= 8'h00;
    cycles(5);
    check8(driver_enable, (m == 2'b00) ? en : 8'hFF, "after fault");
    fault_clear <= 1'b1;
    cycles(1);
    fault_clear <= 1'b0;
    cycles(3);
    check8(driver_enable, 8'hFF, "cleared");
  endtask : fault_case
  task automatic final_report;
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////
  initial begin
    cycles(20);
    reset_n <= 1'b1;
    rd(8'h17, 8'h00);
    rd(8'h18, 8'h00);
    rd(8'h19, 8'h12);
    rd(8'h20, 8'h00);
    $display("test reset values done");
    wr(8'h19, 8'hFF);
    rd(8'h19, 8'h3F);
    wr(8'h17, 8'hA0);
    rd(8'h17, 8'hA0);
    check8(low_current_sel, 8'h05, "low sel");
    check16(peak_current_ua[0], 16'h08FC, "hb1 low");
    check16(peak_current_ua[1], 16'hF230, "hb2 std");
    check16(peak_current_ua[2], 16'h08FC, "hb3 low");
    wr(8'h18, 8'h18); cycles(1);
    check8({6'h00, gate_threshold_select, handshake_disable}, 8'h03, "thr hs");
    wr(8'h18, 8'h08); cycles(1);
    check8({6'h00, gate_threshold_select, handshake_disable}, 8'h01, "thr hs");
    $display("test register fields done");
    for (int i = 0; i < 16; i++) fault_case(i[3], i[1:0], i[2]);
    $display("test fault modes done");
    // code 000 on bridges 1-2: an 80 cycle window hides an overcurrent
    wr(8'h19, 8'h00);
    wr(8'h18, 8'h02);
    switch_cmd <= 8'h01;
    cycles(6);
    check8(blanking_active, 8'h01, "blank on");
    drain_short <= 8'h01;
    cycles(72);
    check8(driver_enable, 8'hFF, "blanked oc");
    check8(blanking_active, 8'h01, "blank held");
    cycles(14);
    check8(blanking_active, 8'h00, "blank off");
    check8(driver_enable, 8'h00, "oc after blank");
    drain_short <= 8'h00;
    $display("test blanking done");
    final_report();
  end
  initial begin
    cycles(5000);
    fail_count++;
    final_report();
  end
endmodule : gate_drive_monitor_config_tb
`default_nettype wire
